/* File: verilog/output_compare_dedicated_timer.sv */
// What this block does
// - Free-running counter wraps FFFF to 0000
// - Match on either compare value gives event
// - Sync mode: run when enabled, sync resets
// - Trigger mode: counter held until trigger
// - Zero sync select means free-running
// - Trigger select bit picks trigger mode
// - 31 event sources, 6 clock sources
// - Odd module low half, even high
// - Odd rollover increments even counter
// - Default state, primary match flips pin
// - Double modes: secondary match restores default
// - Flag on primary single, secondary double
// - Single-shot once; control rewrite re-arms
// - Continuous mode runs until disabled
// - Trigger start after trigger event or software status set
// - Clear mode: secondary match clears status
// - Modes 001, 010, 011 pin behaviour
// - Modes 100, 101 pulses; 000 disables
`timescale 1ns/1ps
`default_nettype none
module output_compare_dedicated_timer
  import oc_pkg::*;
#(
  parameter logic LOW_HALF = 1'b0 // Set in the odd module of a cascaded pair
)
(
  input  wire logic                 mclk,          // System clock
  input  wire logic                 rst_n,         // Async reset, active low
  input  wire ctrl_t                ctrl,          // Control fields
  input  wire logic                 ctrl_one_wr,   // Pulse: control one rewritten
  input  wire logic                 trig_set_sw,   // Pulse: software sets trigger status
  input  wire logic                 trig_clr_sw,   // Pulse: software clears trigger status
  input  wire logic [CNT_W-1:0]     primary_compare_value,   // Primary compare
  input  wire logic [CNT_W-1:0]     secondary_compare_value, // Secondary compare
  input  wire logic [CLK_SRC_N-1:0] tb_tick,       // Time-base count enables
  input  wire logic [CLK_SRC_N-1:0] tb_run,        // Time-base enabled levels
  input  wire logic [31:1]          src_event,     // Sync/trigger event pulses
  input  wire logic                 cascade_carry, // Rollover from odd partner
  output logic      [CNT_W-1:0]     channel_counter, // Counter value
  output logic                      compare_output_pin, // Compare output
  output logic                      compare_interrupt_flag, // One-cycle flag pulse
  output logic                      trigger_armed_status, // Trigger status
  output logic                      rollover_out   // Pulse: counter wrapped
);

  // ****************************************
  // Mode decoding
  // ****************************************
  // Compare modes 001 to 101; the PWM codes are not handled and stay idle
  function automatic logic compare_mode(input logic [2:0] m);
    return (m != MODE_OFF) && (m <= MODE_DBL_CONT);
  endfunction

  // Single compare modes, where the flag follows the primary match
  function automatic logic single_mode(input logic [2:0] m);
    return (m != MODE_OFF) && (m <= MODE_TOGGLE);
  endfunction

  // ****************************************
  // Source selection
  // ****************************************
  logic tick;
  logic run;
  logic ev;
  logic free_run;

  // Chosen clock source and event source
  always_comb
  begin
    tick     = (ctrl.tb_sel < TSEL_W'(CLK_SRC_N)) ? tb_tick[ctrl.tb_sel] : 1'b0;
    run      = (ctrl.tb_sel < TSEL_W'(CLK_SRC_N)) ? tb_run[ctrl.tb_sel] : 1'b0;
    ev       = (ctrl.sync_sel != SYNC_OFF) ? src_event[ctrl.sync_sel] : 1'b0;
    free_run = (ctrl.sync_sel == SYNC_OFF);
  end

  // ****************************************
  // Counter and trigger status
  // ****************************************
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             armed_q, armed_d;
  logic             roll_q, roll_d;
  logic             enabled;
  logic             step;
  logic             match_p;
  logic             match_s;

  always_comb
  begin
    enabled = (ctrl.mode != MODE_OFF) && run;
    // Upper half of a cascaded pair counts on the lower half's wrap;
    // the lower half keeps its own time base and reports its wraps
    step    = (ctrl.cascade && !LOW_HALF) ? cascade_carry : tick;
    match_p = enabled && (cnt_q == primary_compare_value);
    match_s = enabled && (cnt_q == secondary_compare_value);
    cnt_d   = cnt_q;
    roll_d  = 1'b0;
    armed_d = armed_q;
    // Status set wins over any clear in the same cycle
    if (trig_clr_sw || (ctrl.trig_clear_mode && match_s))
      armed_d = 1'b0;
    if (trig_set_sw || (!free_run && ctrl.trig_sel && ev))
      armed_d = 1'b1;
    if (!enabled)
      cnt_d = CNT_RESET;
    else if (!free_run && !ctrl.trig_sel && ev)
      cnt_d = CNT_RESET;
    else if (!free_run && ctrl.trig_sel && !armed_q)
      cnt_d = CNT_RESET;
    else if (step)
    begin
      cnt_d  = cnt_q + 16'h0001;
      // Only the upper half of a pair keeps its wrap to itself
      roll_d = (cnt_q == CNT_MAX) && (LOW_HALF || !ctrl.cascade);
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q   <= CNT_RESET;
      armed_q <= 1'b0;
      roll_q  <= 1'b0;
    end
    else
    begin
      cnt_q   <= cnt_d;
      armed_q <= armed_d;
      roll_q  <= roll_d;
    end
  end

  // ****************************************
  // Output pin state machine
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, // Waiting for primary match; pin at default except in toggle mode, which flips it here
    ST_ACT  = 3'b010, // Pin at opposite state
    ST_DONE = 3'b100  // Single shot finished
  } pin_st_t;

  pin_st_t    st_q, st_d;
  logic       pin_q, pin_d;
  logic       irq_q, irq_d;
  logic [2:0] mode_q;
  logic       dflt;

  always_comb
  begin
    dflt  = (ctrl.mode == MODE_SS_LOW);
    st_d  = st_q;
    pin_d = pin_q;
    irq_d = 1'b0;
    if (!compare_mode(ctrl.mode) || ctrl.mode != mode_q || ctrl_one_wr)
    begin
      st_d  = ST_IDLE;
      pin_d = dflt;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          if (match_p)
          begin
            irq_d = single_mode(ctrl.mode);
            if (ctrl.mode == MODE_TOGGLE)
              pin_d = !pin_q;
            else
            begin
              pin_d = !dflt;
              st_d  = (ctrl.mode <= MODE_SS_LOW) ? ST_DONE : ST_ACT;
            end
          end
        end
        ST_ACT:
        begin
          if (match_s)
          begin
            pin_d = dflt;
            irq_d = 1'b1;
            st_d  = (ctrl.mode == MODE_DBL_CONT) ? ST_IDLE : ST_DONE;
          end
        end
        ST_DONE:
          st_d = ST_DONE;
        default:
          st_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q   <= ST_IDLE;
      pin_q  <= 1'b0;
      irq_q  <= 1'b0;
      mode_q <= MODE_OFF;
    end
    else
    begin
      st_q   <= st_d;
      pin_q  <= pin_d;
      irq_q  <= irq_d;
      mode_q <= ctrl.mode;
    end
  end

  // Outputs straight from flip-flops
  assign channel_counter        = cnt_q;
  assign compare_output_pin     = pin_q;
  assign compare_interrupt_flag = irq_q;
  assign trigger_armed_status   = armed_q;
  assign rollover_out           = roll_q;

endmodule
`default_nettype wire

/* File: verilog/oc_pkg.sv */
`default_nettype none
package oc_pkg;

  // ****************************************
  // Compare mode encodings
  // ****************************************
  localparam logic [2:0] MODE_OFF        = 3'h0;
  localparam logic [2:0] MODE_SS_HIGH    = 3'h1;
  localparam logic [2:0] MODE_SS_LOW     = 3'h2;
  localparam logic [2:0] MODE_TOGGLE     = 3'h3;
  localparam logic [2:0] MODE_DBL_SINGLE = 3'h4;
  localparam logic [2:0] MODE_DBL_CONT   = 3'h5;

  // ****************************************
  // Sizes and reset values
  // ****************************************
  localparam int          CNT_W        = 16;
  localparam int          SRC_W        = 5;
  localparam int          CLK_SRC_N    = 6;
  localparam int          TSEL_W       = 3;
  localparam logic [4:0]  SYNC_OFF     = 5'h00;
  localparam logic [15:0] CNT_RESET    = 16'h0000;
  localparam logic [15:0] CNT_MAX      = 16'hFFFF;

  // Control fields written by software
  typedef struct packed {
    logic [2:0]  mode;            // compare_mode_field
    logic        trig_clear_mode; // trigger_clear_mode
    logic [2:0]  tb_sel;          // time_base_select
    logic        trig_sel;        // trigger_mode_select
    logic [4:0]  sync_sel;        // sync_source_select
    logic        cascade;         // cascade_enable
  } ctrl_t;

  // Output state
  typedef struct packed {
    logic        pin;
    logic        irq;
    logic        armed;
    logic        rollover;
  } stat_t;

endpackage
`default_nettype wire

/* File: verif/pin_load.sv */
`timescale 1ns/1ps
`default_nettype none
// Load on the compare pin, counting its rising edges
module pin_load (
  input  wire logic       mclk,  // Clock
  input  wire logic       pin,   // Pin
  output logic      [7:0] rises  // Edges
);
  logic       pin_q = 1'b0;
  logic [7:0] cnt_q = 8'h00;
  // Edge counter
  always @(posedge mclk)
  begin
    pin_q <= pin;
    if (pin && !pin_q)
      cnt_q <= cnt_q + 8'h01;
  end
  assign rises = cnt_q;
endmodule
`default_nettype wire

/* File: verif/oc_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// Port watcher for the compare channel
module oc_chk
  import oc_pkg::*;
(
  input wire logic                 mclk,                    // Clock
  input wire logic                 rst_n,                   // Reset
  input wire ctrl_t                ctrl,                    // Controls
  input wire logic                 trig_set_sw,             // Set
  input wire logic [CNT_W-1:0]     primary_compare_value,   // Primary
  input wire logic [CNT_W-1:0]     secondary_compare_value, // Secondary
  input wire logic [CLK_SRC_N-1:0] tb_tick,                 // Ticks
  input wire logic [CLK_SRC_N-1:0] tb_run,                  // Runs
  input wire logic [31:1]          src_event,               // Events
  input wire logic [CNT_W-1:0]     channel_counter,         // Counter
  input wire logic                 compare_output_pin,      // Pin
  input wire logic                 compare_interrupt_flag,  // Flag
  input wire logic                 trigger_armed_status,    // Status
  input wire logic                 rollover_out             // Wrap
);
  logic live, free, hit;
  // Step and event conditions
  assign live = ctrl.mode != MODE_OFF && tb_run[ctrl.tb_sel];
  assign free = live && tb_tick[ctrl.tb_sel] && !ctrl.cascade && ctrl.sync_sel == SYNC_OFF;
  assign hit  = ctrl.sync_sel != SYNC_OFF && src_event[ctrl.sync_sel];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_OFF: assert property (ctrl.mode == MODE_OFF |=> channel_counter == 16'h0000)
    else $error("Counter moved while off");
  AST_STEP: assert property (free && channel_counter != CNT_MAX
    |=> channel_counter == $past(channel_counter) + 16'h0001) else $error("No step");
  AST_WRAP: assert property (free && channel_counter == CNT_MAX
    |=> channel_counter == CNT_RESET ##[0:1] rollover_out) else $error("Bad wrap");
  AST_SYNC: assert property (live && !ctrl.trig_sel && hit |=> channel_counter == 16'h0000)
    else $error("Sync missed");
  AST_HOLD: assert property (live && ctrl.trig_sel && ctrl.sync_sel != SYNC_OFF && !hit
    && !trigger_armed_status && !trig_set_sw |=> channel_counter == 16'h0000) else $error("Ran");
  AST_GO: assert property (live && ctrl.trig_sel && hit |=> trigger_armed_status)
    else $error("Trigger lost");
  AST_ACLR: assert property (live && ctrl.trig_clear_mode && trigger_armed_status && !hit
    && !trig_set_sw && channel_counter == secondary_compare_value |=> !trigger_armed_status)
    else $error("Status kept");
  AST_FLAG: assert property (compare_interrupt_flag |-> $past(channel_counter) ==
    $past(primary_compare_value) || $past(channel_counter) == $past(secondary_compare_value))
    else $error("Flag without match");
  cover property (free && channel_counter == CNT_MAX);
  cover property (trigger_armed_status ##1 !trigger_armed_status);
  cover property ($rose(compare_output_pin));
endmodule
bind output_compare_dedicated_timer oc_chk u_chk (.*);
`default_nettype wire

/* File: verif/tb_output_compare_dedicated_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_output_compare_dedicated_timer;
  import oc_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n, ss, sc, wr, carry, pin, flag, stat, roll;
  logic [5:0]  tk, rn;
  ctrl_t       ctrl;
  logic [15:0] pv, sv, cnt;
  logic [31:1] ev;
  logic [7:0]  rises, r0;
  int          error_cnt, n_tests;
  output_compare_dedicated_timer u_dut (.mclk(mclk), .rst_n(rst_n), .ctrl(ctrl),
    .ctrl_one_wr(wr), .trig_set_sw(ss), .trig_clr_sw(sc), .primary_compare_value(pv),
    .secondary_compare_value(sv), .tb_tick(tk), .tb_run(rn), .src_event(ev),
    .cascade_carry(carry), .channel_counter(cnt), .compare_output_pin(pin),
    .compare_interrupt_flag(flag), .trigger_armed_status(stat), .rollover_out(roll));
  pin_load u_load (.mclk(mclk), .pin(pin), .rises(rises));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic end_of_test;
    if (error_cnt == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Idle one cycle with status cleared, then start a mode
  task automatic go(input logic [2:0] md, input logic [15:0] p, input logic [15:0] s);
    ctrl.mode = MODE_OFF;
    sc = 1'b1;
    step(1);
    sc = 1'b0;
    pv = p;
    sv = s;
    ctrl.mode = md;
  endtask
  task automatic t_modes;
    chk("rst cnt", 16'h0000, cnt);
    chk("rst pin", 16'h0000, pin);
    for (int m = 1; m < 6; m++)
    begin
      go(m[2:0], 16'h0002, (m >= 4) ? 16'h0005 : 16'hFFFF);
      for (int k = 1; k < 8; k++)
      begin
        step(1);
        chk("pin", (m == 2) ? k < 3 : (m >= 4) ? k > 2 && k < 6 : k > 2, pin);
        chk("flag", (m >= 4) ? k == 6 : k == 3, flag);
      end
    end
  endtask
  // Single shot fires once, a control rewrite re-arms it
  task automatic t_rearm;
    go(MODE_SS_HIGH, 16'h0002, 16'hFFFF);
    step(4);
    chk("shot", 16'h0001, pin);
    wr = 1'b1;
    pv = 16'h0008;
    step(1);
    wr = 1'b0;
    chk("rearm pin", 16'h0000, pin);
    step(4);
    chk("second shot", 16'h0001, pin);
    chk("second flag", 16'h0001, flag);
  endtask
  task automatic t_sync;
    ctrl.sync_sel = 5'h01;
    go(MODE_TOGGLE, 16'h0002, 16'hFFFF);
    r0 = rises;
    repeat (6)
    begin
      ev[1] = 1'b1;
      step(1);
      ev[1] = 1'b0;
      chk("sync cnt", 16'h0000, cnt);
      step(3);
    end
    chk("rises", 16'h0003, rises - r0);
  endtask
  task automatic t_trig;
    ctrl.trig_sel = 1'b1;
    ctrl.trig_clear_mode = 1'b1;
    ctrl.sync_sel = 5'h02;
    go(MODE_SS_HIGH, 16'h0009, 16'h0004);
    step(3);
    chk("held", 16'h0000, cnt);
    ev[2] = 1'b1;
    step(1);
    ev[2] = 1'b0;
    chk("armed", 16'h0001, stat);
    step(4);
    chk("run", 16'h0004, cnt);
    step(1);
    chk("auto clr", 16'h0000, stat);
    ss = 1'b1;
    step(1);
    ss = 1'b0;
    chk("sw set", 16'h0001, stat);
    step(2);
    chk("sw run", 16'h0002, cnt);
    sc = 1'b1;
    step(1);
    sc = 1'b0;
    chk("sw clr", 16'h0000, stat);
  endtask
  // Time base select, stopped base and missing ticks
  task automatic t_base;
    ctrl = '0;
    ctrl.tb_sel = 3'h3;
    tk = 6'h08;
    rn = 6'h08;
    go(MODE_TOGGLE, 16'h0100, 16'hFFFF);
    step(4);
    chk("base cnt", 16'h0004, cnt);
    rn = 6'h37;
    step(1);
    chk("base stop", 16'h0000, cnt);
    rn = 6'h3F;
    tk = 6'h37;
    step(3);
    chk("no tick", 16'h0000, cnt);
    tk = 6'h3F;
  endtask
  task automatic t_casc;
    ctrl = '0;
    ctrl.cascade = 1'b1;
    go(MODE_SS_HIGH, 16'h0009, 16'hFFFF);
    repeat (3)
    begin
      carry = 1'b1;
      step(1);
      carry = 1'b0;
      step(1);
    end
    chk("carry", 16'h0003, cnt);
  endtask
  task automatic t_wrap;
    ctrl = '0;
    go(MODE_TOGGLE, 16'hFFFF, 16'hFFFF);
    step(65535);
    chk("top", 16'hFFFF, cnt);
    step(1);
    chk("wrap", 16'h0000, cnt);
    chk("wrap pin", 16'h0001, pin);
    chk("roll", 16'h0001, roll);
    step(1);
    chk("roll end", 16'h0000, roll);
  endtask
  // Clock
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  // Main sequence
  initial
  begin
    {rst_n, ss, sc, wr, carry, pv, sv, ev, ctrl} = '0;
    tk = 6'h3F;
    rn = 6'h3F;
    error_cnt = 0;
    n_tests = 0;
    step(12);
    rst_n = 1'b1;
    step(1);
    t_modes;
    t_rearm;
    t_sync;
    t_trig;
    t_base;
    t_casc;
    t_wrap;
    end_of_test;
  end
  // Watchdog
  initial
  begin
    #800us;
    error_cnt++;
    end_of_test;
  end
endmodule
`default_nettype wire
